// ---- rtl/rcs_pkg.sv ----
// What this block does
// [RL1] Run source one, default terminals
// [RL2] Keypad source: RUN key, lit indicator
// [RL3] 2220: two-wire forward/reverse
// [RL4] 3330: three-wire start/stop/direction
// [RL5] Option source, no card: error, no run
// [RL6] Stop method selector, default ramp
// [RL7] Ramp, then brake below start
// [RL8] Coast: output off on removal
// [RL9] Coast: run ignored during off time
// [RL10] DC stop: off time, then braking
// [RL11] DC time from stop time, frequency
// [RL12] Timed coast: wait, then cycle run
// [RL13] Inhibit drops reverse, negative references
// [RL14] Local, remote one, remote two
// [RL15] Set two while function 2 closed
// [RL16] Policy 0: switch needs run cycle
// [RL17] Policy 1: run at new source
// [RL18] Programming mode blocks run in policy 0 only
// [RL19] Policy 2: no programming during output
// [RL20] Run delay, wait message, blinking
// [RL21] Phase order swaps output sequence
// [RL22] Power-up policy for external run
// [RL23] Frequency source codes zero to four
// [RL24] Cycle is low-then-high of run
// [RL25] Power-up 0 needs cycle, 1 starts
package rcs_pkg;
   // **
   // Source codes
   // **
   localparam logic [1:0] RUN_SRC_KEYPAD = 2'h0;
   localparam logic [1:0] RUN_SRC_TERM = 2'h1;
   localparam logic [1:0] RUN_SRC_SERIAL = 2'h2;
   localparam logic [1:0] RUN_SRC_OPTION = 2'h3;
   localparam logic [2:0] FREQ_SRC_KEYPAD = 3'h0;
   localparam logic [2:0] FREQ_SRC_ANALOG = 3'h1;
   localparam logic [2:0] FREQ_SRC_SERIAL = 3'h2;
   localparam logic [2:0] FREQ_SRC_OPTION = 3'h3;
   localparam logic [2:0] FREQ_SRC_PULSE = 3'h4;
   // Control place
   localparam logic [1:0] CTRL_LOCAL = 2'h0;
   localparam logic [1:0] CTRL_REMOTE_ONE = 2'h1;
   localparam logic [1:0] CTRL_REMOTE_TWO = 2'h2;
   // **
   // Stop methods and policies
   // **
   localparam logic [1:0] STOP_RAMP = 2'h0;
   localparam logic [1:0] STOP_COAST = 2'h1;
   localparam logic [1:0] STOP_DC = 2'h2;
   localparam logic [1:0] STOP_TIMED = 2'h3;
   localparam logic [1:0] PROG_BLOCK_RUN = 2'h0;
   localparam logic [1:0] PROG_ALLOW_RUN = 2'h1;
   localparam logic [1:0] PROG_LOCK_RUN = 2'h2;
   // Preset codes
   localparam logic [13:0] PRESET_TWO_WIRE = 14'd2220;
   localparam logic [13:0] PRESET_THREE_WIRE = 14'd3330;
   // Terminal positions
   localparam int TERM_FWD = 0;
   localparam int TERM_REV = 1;
   localparam int TERM_START = 0;
   localparam int TERM_STOP = 1;
   localparam int TERM_DIR = 4;
   localparam int TERM_LOCREM = 6;
   localparam int TERM_EXTSEL = 7;
   // **
   // Timing
   // **
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam logic [9:0] MS_PER_S = 10'd1000;
   localparam logic [3:0] MS_PER_CS = 4'd10;
   localparam int FRAC_BITS = 8;
   localparam logic [7:0] DC_FRAC_FLOOR = 8'h1a;
   localparam int BLINK_BIT = 8;
   localparam int TMR_W = 20;
   // Sequencer states
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_DELAY = 7'b0000010,
      ST_RUN = 7'b0000100,
      ST_RAMP = 7'b0001000,
      ST_BRAKE = 7'b0010000,
      ST_OFF = 7'b0100000,
      ST_DCWAIT = 7'b1000000
   } rcs_state_t;
endpackage : rcs_pkg

// ---- rtl/rcs_sync2.sv ----
`timescale 1ns/1ps
// **
// Two-flop synchroniser
// **
module rcs_sync2 #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // First stage, read only by second
   logic [W-1:0] meta_q;
   // Two stages
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : rcs_sync2

// ---- rtl/rcs_run_stop_ctrl.sv ----
`timescale 1ns/1ps
module rcs_run_stop_ctrl #(
   parameter int TICK_CYC = rcs_pkg::TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   // Pins
   input wire logic [7:0] term_in,
   input wire logic key_run,
   input wire logic key_stop,
   input wire logic local_remote_key,
   input wire logic prog_mode_req,
   // Serial and option run
   input wire logic serial_run,
   input wire logic serial_rev,
   input wire logic option_run,
   input wire logic option_rev,
   input wire logic option_fitted,
   // Settings
   input wire logic [2:0] freq_source_sel_one,
   input wire logic [1:0] run_source_sel_one,
   input wire logic [2:0] freq_source_sel_two,
   input wire logic [1:0] run_source_sel_two,
   input wire logic [1:0] stop_method_sel,
   input wire logic reverse_inhibit_sel,
   input wire logic source_switch_run_policy,
   input wire logic [1:0] program_mode_run_policy,
   input wire logic [9:0] run_delay_time,
   input wire logic phase_order_sel,
   input wire logic powerup_run_policy,
   input wire logic [13:0] init_preset_code,
   input wire logic init_strobe,
   input wire logic [15:0] min_output_off_time,
   input wire logic [15:0] decel_time_one,
   input wire logic [7:0] brake_start_freq,
   input wire logic [6:0] dc_brake_current,
   input wire logic [9:0] dc_brake_stop_time,
   // Drive state
   input wire logic [7:0] out_freq,
   input wire logic freq_ref_neg,
   // Results
   output logic output_enable_q,
   output logic reverse_q,
   output logic phase_swap_q,
   output logic ramp_stop_q,
   output logic [15:0] decel_time_q,
   output logic brake_req_q,
   output logic [6:0] brake_current_q,
   output logic [2:0] freq_src_q,
   output logic freq_neg_block_q,
   output logic [1:0] ctrl_place_q,
   output logic local_remote_led_q,
   output logic option_missing_error_q,
   output logic wait_run_message_q,
   output logic alarm_led_q,
   output logic run_led_q,
   output logic prog_mode_grant_q
);
   import rcs_pkg::*;

   initial begin
      if (TICK_CYC < 2 || TICK_CYC > (1 << 17)) $error("TICK_CYC out of range");
   end

   // **
   // Pin synchronisers
   // **
   logic [7:0] term_s;
   logic [3:0] key_s;
   rcs_sync2 #(.W(8)) u_sync_term (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .d(term_in),
      .q(term_s)
   );
   rcs_sync2 #(.W(4)) u_sync_key (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .d({key_run, key_stop, local_remote_key, prog_mode_req}),
      .q(key_s)
   );

   // **
   // Millisecond tick
   // **
   logic [16:0] div_q;
   logic tick;
   logic [TMR_W-1:0] ms_q;
   assign tick = (div_q == 17'(TICK_CYC - 1));
   // Divider and free ms count
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= '0;
         ms_q <= '0;
      end else if (tick) begin
         div_q <= '0;
         ms_q <= ms_q + 1'b1;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // **
   // Control place and keypad latches
   // **
   logic lr_key_d1_q;
   logic lr_tgl_q;
   logic kp_run_q;
   logic three_wire_q;
   logic tw_run_q;
   logic [1:0] place;
   logic [1:0] run_src;
   // Local/remote toggle, keypad run
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lr_key_d1_q <= 1'b0;
         lr_tgl_q <= 1'b0;
         kp_run_q <= 1'b0;
      end else begin
         lr_key_d1_q <= key_s[1];
         if (key_s[1] && !lr_key_d1_q) begin
            lr_tgl_q <= ~lr_tgl_q;
         end
         // Keypad run stays until stop
         if (key_s[2]) begin
            kp_run_q <= 1'b0;
         end else if (key_s[3]) begin
            kp_run_q <= 1'b1;
         end
      end
   end
   // [RL14] place from key or inputs
   // [RL15] set two on extsel only
   always_comb begin
      if (lr_tgl_q ^ term_s[TERM_LOCREM]) begin
         place = CTRL_LOCAL;
         run_src = RUN_SRC_KEYPAD;
      end else if (term_s[TERM_EXTSEL]) begin
         place = CTRL_REMOTE_TWO;
         run_src = run_source_sel_two;
      end else begin
         place = CTRL_REMOTE_ONE;
         // [RL1] remote one source
         run_src = run_source_sel_one;
      end
   end

   // **
   // Terminal sequence
   // **
   // [RL3] [RL4] preset picks wiring
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         three_wire_q <= 1'b0;
      end else if (init_strobe) begin
         if (init_preset_code == PRESET_THREE_WIRE) begin
            three_wire_q <= 1'b1;
         end else if (init_preset_code == PRESET_TWO_WIRE) begin
            three_wire_q <= 1'b0;
         end
      end
   end
   // [RL4] three-wire start latch
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tw_run_q <= 1'b0;
      end else if (!term_s[TERM_STOP]) begin
         tw_run_q <= 1'b0;
      end else if (term_s[TERM_START]) begin
         tw_run_q <= 1'b1;
      end
   end

   // **
   // Selected run request
   // **
   logic req_run;
   logic req_rev;
   logic opt_err;
   logic req;
   always_comb begin
      req_run = 1'b0;
      req_rev = 1'b0;
      opt_err = 1'b0;
      case (run_src)
         // [RL2] keypad key only
         RUN_SRC_KEYPAD: req_run = kp_run_q;
         RUN_SRC_TERM: begin
            if (three_wire_q) begin
               req_run = tw_run_q;
               req_rev = term_s[TERM_DIR];
            end else begin
               // [RL3] fwd xor rev terminal
               req_run = term_s[TERM_FWD] ^ term_s[TERM_REV];
               req_rev = term_s[TERM_REV];
            end
         end
         RUN_SRC_SERIAL: begin
            req_run = serial_run;
            req_rev = serial_rev;
         end
         RUN_SRC_OPTION: begin
            // [RL5] no card, no run
            opt_err = !option_fitted;
            req_run = option_run && option_fitted;
            req_rev = option_rev;
         end
         default: req_run = 1'b0;
      endcase
   end
   // [RL13] reverse request dropped
   // [RL18] programming mode blocks run in policy 0
   assign req = req_run && !(reverse_inhibit_sel && req_rev) &&
                !(key_s[0] && program_mode_run_policy == PROG_BLOCK_RUN);

   // **
   // Run cycling interlock
   // **
   rcs_state_t st_q;
   logic [1:0] src_d1_q;
   logic [2:0] first_q; // Power-up window, spans sync delay
   logic cyc_q;
   logic cyc_set;
   assign cyc_set = req && (
      // [RL16] policy 0 on source change
      (src_d1_q != run_src && !source_switch_run_policy) ||
      // [RL22] [RL25] power-up policy
      (first_q[0] && !powerup_run_policy && run_src != RUN_SRC_KEYPAD) ||
      // [RL12] run during timed wait
      (st_q == ST_OFF && stop_method_sel == STOP_TIMED));
   // [RL24] clear on low, set wins
   // [RL17] policy 1 sets nothing
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         src_d1_q <= RUN_SRC_TERM;
         first_q <= 3'h7;
         cyc_q <= 1'b0;
      end else begin
         src_d1_q <= run_src;
         first_q <= first_q >> 1;
         if (cyc_set) begin
            cyc_q <= 1'b1;
         end else if (!req) begin
            cyc_q <= 1'b0;
         end
      end
   end

   logic go;
   assign go = req && !cyc_q && !cyc_set;

   // **
   // Stop time arithmetic
   // **
   logic [7:0] f_stop_q;
   logic [7:0] f_dc;
   logic [TMR_W-1:0] dly_ms;
   logic [TMR_W-1:0] dc_ms;
   logic [TMR_W-1:0] wait_ms;
   logic [TMR_W-1:0] off_ms;
   logic [TMR_W-1:0] brk_ms;
   logic [23:0] dc_prod;
   logic [23:0] wait_prod;
   assign dly_ms = TMR_W'(run_delay_time) * TMR_W'(MS_PER_S);
   assign off_ms = TMR_W'(min_output_off_time);
   assign brk_ms = TMR_W'(dc_brake_stop_time) * TMR_W'(MS_PER_CS);
   // [RL11] stop time times frequency
   assign f_dc = (f_stop_q < DC_FRAC_FLOOR) ? DC_FRAC_FLOOR : f_stop_q;
   assign dc_prod = 24'(brk_ms) * 24'(f_dc);
   assign dc_ms = TMR_W'(dc_prod >> FRAC_BITS);
   // [RL12] wait from frequency, decel
   assign wait_prod = 24'(decel_time_one) * 24'(out_freq);
   assign wait_ms = TMR_W'(wait_prod >> FRAC_BITS);

   // **
   // Stop sequencer
   // **
   logic [TMR_W-1:0] tmr_q;
   logic tmr_done;
   assign tmr_done = (tmr_q == '0);
   // State, timer, stop frequency latch
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= ST_IDLE;
         tmr_q <= '0;
         f_stop_q <= '0;
      end else begin
         if (tick && !tmr_done) begin
            tmr_q <= tmr_q - 1'b1;
         end
         case (st_q)
            ST_IDLE: begin
               // [RL20] delay before run
               if (go) begin
                  tmr_q <= dly_ms;
                  st_q <= ST_DELAY;
               end
            end
            ST_DELAY: begin
               if (!go) begin
                  st_q <= ST_IDLE;
               end else if (tmr_done) begin
                  st_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (!go) begin
                  f_stop_q <= out_freq;
                  case (stop_method_sel)
                     // [RL7] ramp down
                     STOP_RAMP: st_q <= ST_RAMP;
                     // [RL10] output off first
                     STOP_DC: begin
                        tmr_q <= off_ms;
                        st_q <= ST_DCWAIT;
                     end
                     // [RL12] timed coast wait
                     STOP_TIMED: begin
                        tmr_q <= wait_ms;
                        st_q <= ST_OFF;
                     end
                     // [RL8] [RL9] coast, off time
                     default: begin
                        tmr_q <= off_ms;
                        st_q <= ST_OFF;
                     end
                  endcase
               end
            end
            ST_RAMP: begin
               if (go) begin
                  st_q <= ST_RUN;
               end else if (out_freq < brake_start_freq) begin
                  // [RL7] brake below start
                  tmr_q <= brk_ms;
                  st_q <= ST_BRAKE;
               end
            end
            ST_DCWAIT: begin
               // [RL10] then braking current
               if (tmr_done) begin
                  tmr_q <= dc_ms;
                  st_q <= ST_BRAKE;
               end
            end
            ST_BRAKE: begin
               if (tmr_done) begin
                  st_q <= ST_IDLE;
               end
            end
            ST_OFF: begin
               // [RL9] run ignored until done
               if (tmr_done) begin
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // **
   // Registered outputs
   // **
   logic active;
   logic blink;
   assign active = (st_q == ST_RUN) || (st_q == ST_RAMP);
   assign blink = ms_q[BLINK_BIT];
   // Output stage controls
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         output_enable_q <= 1'b0;
         reverse_q <= 1'b0;
         phase_swap_q <= 1'b0;
         ramp_stop_q <= 1'b0;
         decel_time_q <= '0;
         brake_req_q <= 1'b0;
         brake_current_q <= '0;
      end else begin
         // [RL8] coast drops enable at once
         output_enable_q <= active;
         if (st_q == ST_IDLE && go) begin
            reverse_q <= req_rev;
         end
         // [RL21] phase order swap
         phase_swap_q <= phase_order_sel;
         ramp_stop_q <= (st_q == ST_RAMP);
         decel_time_q <= decel_time_one;
         brake_req_q <= (st_q == ST_BRAKE);
         brake_current_q <= (st_q == ST_BRAKE) ? dc_brake_current : 7'h00;
      end
   end
   // Indicators and sources
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         freq_src_q <= FREQ_SRC_ANALOG;
         freq_neg_block_q <= 1'b0;
         ctrl_place_q <= CTRL_REMOTE_ONE;
         local_remote_led_q <= 1'b0;
         option_missing_error_q <= 1'b0;
         wait_run_message_q <= 1'b0;
         alarm_led_q <= 1'b0;
         run_led_q <= 1'b0;
         prog_mode_grant_q <= 1'b0;
      end else begin
         // [RL23] [RL15] frequency source
         case (place)
            CTRL_LOCAL: freq_src_q <= FREQ_SRC_KEYPAD;
            CTRL_REMOTE_TWO: freq_src_q <= freq_source_sel_two;
            default: freq_src_q <= freq_source_sel_one;
         endcase
         // [RL13] negative reference blocked
         freq_neg_block_q <= reverse_inhibit_sel && freq_ref_neg;
         ctrl_place_q <= place;
         // [RL2] indicator for keypad source
         local_remote_led_q <= (run_src == RUN_SRC_KEYPAD);
         option_missing_error_q <= opt_err;
         // [RL20] wait message, blinking
         wait_run_message_q <= (st_q == ST_DELAY);
         alarm_led_q <= (st_q == ST_DELAY) && blink;
         run_led_q <= (st_q == ST_DELAY) ? blink : active;
         // [RL19] [RL18] programming grant
         prog_mode_grant_q <= key_s[0] &&
            !(program_mode_run_policy == PROG_LOCK_RUN && (active || st_q == ST_BRAKE));
      end
   end
endmodule : rcs_run_stop_ctrl

// ---- dv/rcs_far_model.sv ----
`timescale 1ns/1ps
// **
// Keypad, terminals and fieldbus host
// **
module rcs_far_model
   import rcs_pkg::*;
(
   input wire logic want_fwd,
   input wire logic want_rev,
   input wire logic ext_sel,
   input wire logic all_src,
   input wire logic [1:0] run_source_sel_one,
   output logic [7:0] term_in,
   output logic key_run,
   output logic key_stop,
   output logic serial_run,
   output logic serial_rev,
   output logic option_run,
   output logic option_rev
);
   logic t_on, k_on, s_on, o_on; // Which source carries the request
   assign t_on = all_src || run_source_sel_one == RUN_SRC_TERM;
   assign k_on = run_source_sel_one == RUN_SRC_KEYPAD;
   assign s_on = all_src || run_source_sel_one == RUN_SRC_SERIAL;
   assign o_on = all_src || run_source_sel_one == RUN_SRC_OPTION;
   assign term_in = {ext_sel, 5'h00, t_on ? {want_rev, want_fwd} : 2'h0};
   assign key_run = k_on && (want_fwd || want_rev);
   assign key_stop = k_on && !(want_fwd || want_rev);
   assign serial_run = s_on && want_fwd;
   assign serial_rev = s_on && want_rev;
   assign option_run = o_on && want_fwd;
   assign option_rev = o_on && want_rev;
endmodule : rcs_far_model

// ---- dv/rcs_run_stop_checker.sv ----
`timescale 1ns/1ps
// **
// Output relations
// **
module rcs_run_stop_checker
   import rcs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [1:0] stop_method_sel,
   input wire logic reverse_inhibit_sel,
   input wire logic [1:0] program_mode_run_policy,
   input wire logic phase_order_sel,
   input wire logic [6:0] dc_brake_current,
   input wire logic output_enable_q,
   input wire logic reverse_q,
   input wire logic phase_swap_q,
   input wire logic ramp_stop_q,
   input wire logic brake_req_q,
   input wire logic [6:0] brake_current_q,
   input wire logic freq_neg_block_q,
   input wire logic option_missing_error_q,
   input wire logic wait_run_message_q,
   input wire logic prog_mode_grant_q
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   property p_ramp_en; ramp_stop_q |-> output_enable_q; endproperty
   a_ramp_en: assert property (p_ramp_en) else $error("ramp flag without output");
   property p_brk_off; brake_req_q |-> !output_enable_q; endproperty
   a_brk_off: assert property (p_brk_off) else $error("brake with output on");
   property p_brk_cur;
      brake_current_q == (brake_req_q ? $past(dc_brake_current) : 7'h00);
   endproperty
   a_brk_cur: assert property (p_brk_cur) else $error("brake current wrong");
   property p_coast;
      $fell(output_enable_q) && stop_method_sel == STOP_COAST |-> !output_enable_q [*8];
   endproperty
   a_coast: assert property (p_coast) else $error("restart inside off time");
   property p_wait; wait_run_message_q |-> !output_enable_q; endproperty
   a_wait: assert property (p_wait) else $error("output on while waiting");
   property p_phase;
      $changed(phase_order_sel) |-> ##[1:3] phase_swap_q == phase_order_sel;
   endproperty
   a_phase: assert property (p_phase) else $error("phase swap not followed");
   property p_rev; $rose(reverse_q) |-> !$past(reverse_inhibit_sel); endproperty
   a_rev: assert property (p_rev) else $error("reverse while inhibited");
   property p_neg; $rose(freq_neg_block_q) |-> $past(reverse_inhibit_sel); endproperty
   a_neg: assert property (p_neg) else $error("negative block without inhibit");
   property p_opt; $rose(output_enable_q) |-> !$past(option_missing_error_q); endproperty
   a_opt: assert property (p_opt) else $error("start with card missing");
   property p_lock;
      program_mode_run_policy == PROG_LOCK_RUN && $stable(program_mode_run_policy)
         && output_enable_q |-> !prog_mode_grant_q;
   endproperty
   a_lock: assert property (p_lock) else $error("programming granted in run");
   c_brake: cover property (brake_req_q);
   c_wait: cover property (wait_run_message_q);
   c_coast: cover property ($fell(output_enable_q) && stop_method_sel == STOP_COAST);
endmodule : rcs_run_stop_checker
bind rcs_run_stop_ctrl rcs_run_stop_checker i_chk (.*);

// ---- dv/rcs_run_stop_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module rcs_run_stop_ctrl_tb_top;
   import rcs_pkg::*;
   // **
   // Stimulus and observed signals
   // **
   logic ref_clk = 1'b0, arst_n = 1'b0;
   logic want_fwd = 1'b0, want_rev = 1'b0, ext_sel = 1'b0, all_src = 1'b0;
   logic [7:0] term_in;
   logic key_run, key_stop, serial_run, serial_rev, option_run, option_rev;
   logic local_remote_key = 1'b0, prog_mode_req = 1'b0, option_fitted = 1'b0;
   logic [2:0] freq_source_sel_one = FREQ_SRC_ANALOG, freq_source_sel_two = FREQ_SRC_KEYPAD;
   logic [1:0] run_source_sel_one = RUN_SRC_TERM, run_source_sel_two = RUN_SRC_KEYPAD;
   logic [1:0] stop_method_sel = STOP_COAST, program_mode_run_policy = PROG_BLOCK_RUN;
   logic reverse_inhibit_sel = 1'b0, source_switch_run_policy = 1'b0, phase_order_sel = 1'b0;
   logic powerup_run_policy = 1'b0, init_strobe = 1'b0, freq_ref_neg = 1'b0;
   logic [9:0] run_delay_time = 10'h000, dc_brake_stop_time = 10'h002;
   logic [13:0] init_preset_code = PRESET_TWO_WIRE;
   logic [15:0] min_output_off_time = 16'h0005, decel_time_one = 16'h0064;
   logic [7:0] brake_start_freq = 8'h10, out_freq = 8'h80;
   logic [6:0] dc_brake_current = 7'h32, brake_current_q;
   logic output_enable_q, reverse_q, phase_swap_q, ramp_stop_q, brake_req_q;
   logic freq_neg_block_q, local_remote_led_q, option_missing_error_q;
   logic wait_run_message_q, alarm_led_q, run_led_q, prog_mode_grant_q;
   logic [15:0] decel_time_q;
   logic [2:0] freq_src_q;
   logic [1:0] ctrl_place_q;
   int err_total = 0, total_checks = 0;
   // One millisecond is ten clocks here
   rcs_run_stop_ctrl #(.TICK_CYC(10)) i_dut (.*);
   rcs_far_model i_far (.*);
   always #5 ref_clk = ~ref_clk;
   // **
   // Shared tasks
   // **
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   task idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : idle
   // Bounded wait: 0 enable, 1 brake, 2 grant
   task wt(input int sel, input logic v, input int n);
      logic s;
      for (int i = 0; i < n; i++) begin
         @(negedge ref_clk);
         s = (sel == 0) ? output_enable_q : (sel == 1) ? brake_req_q : prog_mode_grant_q;
         if (s === v) return;
      end
      err_total++;
      $display("[ERR] wait %0d exp %0h got timeout", sel, v);
      stop_test();
   endtask : wt
   // Start; drop and let coast end
   task run_on;
      want_fwd = 1'b1;
      wt(0, 1'b1, 20);
   endtask : run_on
   task run_off;
      want_fwd = 1'b0;
      wt(0, 1'b0, 6);
      idle(60);
   endtask : run_off
   task brake_len(input int e);
      int c;
      c = 0;
      wt(1, 1'b1, 80);
      `CHK("brake_cur", dc_brake_current, brake_current_q)
      while (brake_req_q === 1'b1 && c < 1000) begin
         @(negedge ref_clk);
         c++;
      end
      `CHK("brake_len", 1'b1, (c > e - 12 && c < e + 12))
   endtask : brake_len
   // **
   // Scenarios
   // **
   task t_coast;
      run_on();
      `CHK("fwd_dir", 1'b0, reverse_q)
      want_fwd = 1'b0;
      wt(0, 1'b0, 6);
      want_fwd = 1'b1;
      idle(35);
      `CHK("off_hold", 1'b0, output_enable_q)
      wt(0, 1'b1, 40);
      run_off();
      $display("coast done");
   endtask : t_coast
   task t_stops;
      stop_method_sel = STOP_RAMP;
      run_on();
      want_fwd = 1'b0;
      idle(6);
      `CHK("ramp", 1'b1, ramp_stop_q)
      `CHK("ramp_en", 1'b1, output_enable_q)
      `CHK("decel", decel_time_one, decel_time_q)
      out_freq = 8'h08;
      brake_len(200);
      out_freq = 8'h80;
      stop_method_sel = STOP_DC;
      run_on();
      want_fwd = 1'b0;
      wt(0, 1'b0, 6);
      idle(40);
      `CHK("dc_early", 1'b0, brake_req_q)
      brake_len(100);
      stop_method_sel = STOP_TIMED;
      run_on();
      want_fwd = 1'b0;
      idle(20);
      want_fwd = 1'b1;
      idle(600);
      `CHK("timed_hold", 1'b0, output_enable_q)
      want_fwd = 1'b0;
      idle(3);
      run_on();
      want_fwd = 1'b0;
      idle(600);
      stop_method_sel = STOP_COAST;
      $display("stop methods done");
   endtask : t_stops
   task t_sources;
      reverse_inhibit_sel = 1'b1;
      freq_ref_neg = 1'b1;
      want_rev = 1'b1;
      idle(30);
      `CHK("rev_inh", 1'b0, output_enable_q)
      `CHK("neg_blk", 1'b1, freq_neg_block_q)
      reverse_inhibit_sel = 1'b0;
      wt(0, 1'b1, 20);
      `CHK("rev_dir", 1'b1, reverse_q)
      want_rev = 1'b0;
      freq_ref_neg = 1'b0;
      idle(60);
      run_source_sel_one = RUN_SRC_OPTION;
      want_fwd = 1'b1;
      idle(10);
      `CHK("opt_err", 1'b1, option_missing_error_q)
      `CHK("opt_run", 1'b0, output_enable_q)
      option_fitted = 1'b1;
      wt(0, 1'b1, 20);
      run_off();
      run_source_sel_one = RUN_SRC_KEYPAD;
      run_on();
      `CHK("lr_led", 1'b1, local_remote_led_q)
      run_off();
      run_source_sel_one = RUN_SRC_TERM;
      all_src = 1'b1;
      run_on();
      run_source_sel_one = RUN_SRC_SERIAL;
      wt(0, 1'b0, 6);
      idle(80);
      `CHK("sw_hold", 1'b0, output_enable_q)
      want_fwd = 1'b0;
      idle(3);
      run_on();
      source_switch_run_policy = 1'b1;
      run_source_sel_one = RUN_SRC_TERM;
      idle(10);
      `CHK("sw_keep", 1'b1, output_enable_q)
      run_off();
      all_src = 1'b0;
      $display("sources done");
   endtask : t_sources
   task t_modes;
      prog_mode_req = 1'b1;
      want_fwd = 1'b1;
      idle(30);
      `CHK("prog_blk", 1'b0, output_enable_q)
      program_mode_run_policy = PROG_ALLOW_RUN;
      wt(0, 1'b1, 20);
      program_mode_run_policy = PROG_LOCK_RUN;
      idle(4);
      `CHK("grant_run", 1'b0, prog_mode_grant_q)
      want_fwd = 1'b0;
      wt(2, 1'b1, 80);
      prog_mode_req = 1'b0;
      idle(60);
      run_delay_time = 10'h001;
      phase_order_sel = 1'b1;
      want_fwd = 1'b1;
      idle(9000);
      `CHK("wait_msg", 1'b1, wait_run_message_q)
      `CHK("delay_off", 1'b0, output_enable_q)
      `CHK("phase", 1'b1, phase_swap_q)
      wt(0, 1'b1, 1200);
      run_off();
      run_delay_time = 10'h000;
      init_preset_code = PRESET_THREE_WIRE;
      init_strobe = 1'b1;
      want_rev = 1'b1;
      idle(1);
      init_strobe = 1'b0;
      run_on();
      want_fwd = 1'b0;
      idle(10);
      `CHK("tw_hold", 1'b1, output_enable_q)
      want_rev = 1'b0;
      run_off();
      ext_sel = 1'b1;
      freq_source_sel_two = FREQ_SRC_PULSE;
      idle(5);
      `CHK("place_two", CTRL_REMOTE_TWO, ctrl_place_q)
      `CHK("fsrc_two", FREQ_SRC_PULSE, freq_src_q)
      ext_sel = 1'b0;
      local_remote_key = 1'b1;
      idle(5);
      `CHK("place_loc", CTRL_LOCAL, ctrl_place_q)
      $display("modes done");
   endtask : t_modes
   // **
   // Main sequence
   // **
   initial begin
      idle(5);
      arst_n = 1'b1;
      `CHK("rst_fsrc", FREQ_SRC_ANALOG, freq_src_q)
      `CHK("rst_place", CTRL_REMOTE_ONE, ctrl_place_q)
      init_strobe = 1'b1;
      idle(1);
      init_strobe = 1'b0;
      idle(3);
      t_coast();
      t_stops();
      t_sources();
      t_modes();
      stop_test();
   end
endmodule : rcs_run_stop_ctrl_tb_top
